/* rtl/gcr_general_control.sv */
// General control register bank of the bridge driver with watchdog handling.
//
// Summary of operation
// - Each write to control one must invert the toggle, else fail safe.
// - After reset the watchdog toggle bit reads zero.
// - Period select gives 50 ms when clear, 200 ms when set; set by default.
// - Unlock bit seven allows setting the disable bit only in the next frame.
// - Disable bit nine stops the watchdog only right after an unlocking frame.
// - Clearing the disable bit re-enables the watchdog at once, no unlock needed.
// - Bank select bit nine routes shared offsets to active or free-wheeling set.
// - Addresses 05, 0A, 0B, 0C, 0D decode per bank; others are bank independent.
// - Gain codes 00, 01, 10, 11 mean 10, 20, 40, 80 volts per volt.
// - Direction bits 15 and 12 select unidirectional at zero, bidirectional at one.
// - Overvoltage level bit eight picks the low threshold at zero, high at one.
// - Reserved bits six and four of control one read zero, ignore writes.
// - Spread bit five off means no modulation; on gives 15.6 kHz modulation.
// - Adaptation step bit three selects one current step or two per adaptation.
// - Postcharge disable bit 15 of control two suppresses postcharge when set.
// - Passive bit 14 puts the bridge in passive mode; passive after reset.
// - Adaptive gate filter bit 13 enables filtering of charge-current adaptation.
// - Mode 00 all off, 01 pre-discharge only, 10 and 11 self adapting.
// - Hold current bit ten selects the lower or higher hold current pair.
// - Delay registers for channels two, three at 0F and 10, reset 0A0A.
`timescale 1ns/1ns
`default_nettype none
module gcr_general_control #(
    parameter int CYC_PER_MS = gcr_pkg::CYC_PER_MS
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        frame_done,
    input  wire logic        frame_wr,
    input  wire logic [4:0]  frame_addr,
    input  wire logic [15:0] frame_wdata,
    output logic      [15:0] frame_rdata,
    output logic             frame_rvalid,
    output logic             ext_valid,
    output logic             ext_wr,
    output logic      [4:0]  ext_addr,
    output logic             ext_bank_alt,
    output logic      [15:0] ext_wdata,
    input  wire logic [15:0] ext_rdata,
    output logic             fail_safe,
    output logic             watchdog_active,
    output logic             watchdog_period_select,
    output logic             overcurrent_enable,
    output logic             precharge_adapt_step,
    output logic             spread_modulation,
    output logic             spread_tick,
    output logic             supply_overvoltage_level,
    output logic             bank_select,
    output logic      [1:0]  sense_gain_one,
    output logic      [1:0]  sense_gain_two,
    output logic      [6:0]  sense_gain_one_vpv,
    output logic      [6:0]  sense_gain_two_vpv,
    output logic             sense_direction_one,
    output logic             sense_direction_two,
    output logic             postcharge_disable,
    output logic             bridge_passive,
    output logic             adaptive_gate_filter,
    output logic      [1:0]  adaptive_gate_mode,
    output logic             adapt_enable,
    output logic             precharge_enable,
    output logic             predischarge_enable,
    output logic             gate_hold_current_select,
    output logic      [8:0]  general_control_two_low,
    output logic      [15:0] pwm2_switch_delays,
    output logic      [15:0] pwm3_switch_delays
);
    localparam logic [10:0] SPREAD_LAST = 11'(gcr_pkg::SPREAD_CYC - 1);

    // Reset release synchroniser.
    logic [1:0]  rst_pipe;
    logic        rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_b = rst_pipe[1];

    // Register state.
    logic [15:0] general_control_one;
    logic [15:0] general_control_two;
    logic [15:0] next_gctrl1;
    logic [15:0] next_gctrl2;
    logic [15:0] next_dly2;
    logic [15:0] next_dly3;
    logic        unlock_prev;
    logic        next_unlock_prev;
    logic        fail_q;
    logic        next_fail;
    logic        wr_frame;

    gcr_wdg_if wdg ();

    gcr_watchdog #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_watchdog (
        .clk        (clk),
        .rst_sync_b (rst_sync_b),
        .wdg        (wdg.timer)
    );

    always_comb begin
        wr_frame         = frame_done && frame_wr;
        next_gctrl1      = general_control_one;
        next_gctrl2      = general_control_two;
        next_dly2        = pwm2_switch_delays;
        next_dly3        = pwm3_switch_delays;
        next_fail        = fail_q;
        // Any complete frame closes the unlock window of the frame before it.
        next_unlock_prev = frame_done ? 1'b0 : unlock_prev;
        if (wr_frame) begin
            if (frame_addr == gcr_pkg::OFS_GCTRL1) begin
                next_gctrl1      = frame_wdata & gcr_pkg::GCTRL1_WMASK;
                next_unlock_prev = frame_wdata[gcr_pkg::B1_UNLOCK];
                if (frame_wdata[gcr_pkg::B1_TOGGLE] == general_control_one[gcr_pkg::B1_TOGGLE]) begin
                    next_fail = 1'b1;
                end
            end else if (frame_addr == gcr_pkg::OFS_GCTRL2) begin
                next_gctrl2 = frame_wdata;
                // Setting needs the unlock frame just before; clearing never does.
                next_gctrl2[gcr_pkg::B2_WDG_DIS] = frame_wdata[gcr_pkg::B2_WDG_DIS]
                    && (general_control_two[gcr_pkg::B2_WDG_DIS] || unlock_prev);
            end else if (frame_addr == gcr_pkg::OFS_PWM2_DLY) begin
                next_dly2 = frame_wdata;
            end else if (frame_addr == gcr_pkg::OFS_PWM3_DLY) begin
                next_dly3 = frame_wdata;
            end
        end
        // Fail safe is held until reset; only asserting rst_b leaves it.
        if (wdg.expired) begin
            next_fail = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            general_control_one <= gcr_pkg::RST_GCTRL1;
            general_control_two <= gcr_pkg::RST_GCTRL2;
            pwm2_switch_delays  <= gcr_pkg::RST_DLY;
            pwm3_switch_delays  <= gcr_pkg::RST_DLY;
            unlock_prev         <= 1'b0;
            fail_q              <= 1'b0;
        end else begin
            general_control_one <= next_gctrl1;
            general_control_two <= next_gctrl2;
            pwm2_switch_delays  <= next_dly2;
            pwm3_switch_delays  <= next_dly3;
            unlock_prev         <= next_unlock_prev;
            fail_q              <= next_fail;
        end
    end

    // A valid toggle write restarts the window; the disable bit stops it.
    assign wdg.kick        = wr_frame && (frame_addr == gcr_pkg::OFS_GCTRL1)
        && (frame_wdata[gcr_pkg::B1_TOGGLE] != general_control_one[gcr_pkg::B1_TOGGLE]);
    assign wdg.enable      = !general_control_two[gcr_pkg::B2_WDG_DIS];
    assign wdg.period_long = general_control_one[gcr_pkg::B1_PERIOD];

    // Read and forward pipeline: forward in the cycle after the frame, answer one later.
    logic        own_hit;
    logic        rd_pend;
    logic        next_rd_pend;
    logic        rd_own;
    logic        next_rd_own;
    logic [15:0] own_data;
    logic [15:0] next_own_data;
    logic        next_ext_valid;
    logic        next_ext_bank_alt;
    logic        next_rvalid;
    logic [15:0] next_rdata;

    always_comb begin
        own_hit       = 1'b1;
        next_own_data = 16'h0000;
        if (frame_addr == gcr_pkg::OFS_GCTRL1) begin
            next_own_data = general_control_one;
        end else if (frame_addr == gcr_pkg::OFS_GCTRL2) begin
            next_own_data = general_control_two;
        end else if (frame_addr == gcr_pkg::OFS_PWM2_DLY) begin
            next_own_data = pwm2_switch_delays;
        end else if (frame_addr == gcr_pkg::OFS_PWM3_DLY) begin
            next_own_data = pwm3_switch_delays;
        end else begin
            own_hit = 1'b0;
        end
        next_rd_pend      = frame_done && !frame_wr;
        next_rd_own       = own_hit;
        next_ext_valid    = frame_done && !own_hit;
        next_ext_bank_alt = gcr_pkg::is_banked(frame_addr)
            && general_control_one[gcr_pkg::B1_BANK];
        next_rvalid       = rd_pend;
        next_rdata        = rd_own ? own_data : ext_rdata;
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rd_pend      <= 1'b0;
            rd_own       <= 1'b0;
            own_data     <= 16'h0000;
            ext_valid    <= 1'b0;
            ext_wr       <= 1'b0;
            ext_addr     <= 5'h00;
            ext_bank_alt <= 1'b0;
            ext_wdata    <= 16'h0000;
            frame_rvalid <= 1'b0;
            frame_rdata  <= 16'h0000;
        end else begin
            rd_pend      <= next_rd_pend;
            rd_own       <= next_rd_own;
            own_data     <= next_own_data;
            ext_valid    <= next_ext_valid;
            ext_wr       <= frame_wr;
            ext_addr     <= frame_addr;
            ext_bank_alt <= next_ext_bank_alt;
            ext_wdata    <= frame_wdata;
            frame_rvalid <= next_rvalid;
            frame_rdata  <= next_rdata;
        end
    end

    // Modulation rate divider; it idles at zero so the first tick is a full period away.
    logic [10:0] spread_cnt;
    logic [10:0] next_spread_cnt;
    logic        next_spread_tick;

    always_comb begin
        next_spread_cnt  = 11'h000;
        next_spread_tick = 1'b0;
        if (general_control_one[gcr_pkg::B1_SPREAD]) begin
            if (spread_cnt == SPREAD_LAST) begin
                next_spread_tick = 1'b1;
            end else begin
                next_spread_cnt = spread_cnt + 11'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            spread_cnt  <= 11'h000;
            spread_tick <= 1'b0;
        end else begin
            spread_cnt  <= next_spread_cnt;
            spread_tick <= next_spread_tick;
        end
    end

    // Field outputs from the register flip-flops; watchdog_active is inverted and the gain values are decoded.
    assign fail_safe                = fail_q;
    assign watchdog_active          = !general_control_two[gcr_pkg::B2_WDG_DIS];
    assign watchdog_period_select   = general_control_one[gcr_pkg::B1_PERIOD];
    assign overcurrent_enable       = general_control_one[gcr_pkg::B1_OC_EN];
    assign precharge_adapt_step     = general_control_one[gcr_pkg::B1_ADAPT_STEP];
    assign spread_modulation        = general_control_one[gcr_pkg::B1_SPREAD];
    assign supply_overvoltage_level = general_control_one[gcr_pkg::B1_OV_LEVEL];
    assign bank_select              = general_control_one[gcr_pkg::B1_BANK];
    assign sense_gain_one           = general_control_one[gcr_pkg::B1_GAIN1_LO +: 2];
    assign sense_gain_two           = general_control_one[gcr_pkg::B1_GAIN2_LO +: 2];
    assign sense_gain_one_vpv       = gcr_pkg::GAIN_BASE << sense_gain_one;
    assign sense_gain_two_vpv       = gcr_pkg::GAIN_BASE << sense_gain_two;
    assign sense_direction_one      = general_control_one[gcr_pkg::B1_DIR1];
    assign sense_direction_two      = general_control_one[gcr_pkg::B1_DIR2];
    assign postcharge_disable       = general_control_two[gcr_pkg::B2_POST_DIS];
    assign bridge_passive           = general_control_two[gcr_pkg::B2_PASSIVE];
    assign adaptive_gate_filter     = general_control_two[gcr_pkg::B2_FILTER];
    assign adaptive_gate_mode       = general_control_two[gcr_pkg::B2_AGC_LO +: 2];
    assign gate_hold_current_select = general_control_two[gcr_pkg::B2_HOLD];
    assign general_control_two_low  = general_control_two[8:0];

    // The reserved code 11 behaves as the self-adapting mode.
    assign adapt_enable        = adaptive_gate_mode[1];
    assign precharge_enable    = adaptive_gate_mode[1];
    assign predischarge_enable = (adaptive_gate_mode != gcr_pkg::AGC_OFF);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_b);

    a_toggle_keep_fail: assert property (
        wr_frame && frame_addr == gcr_pkg::OFS_GCTRL1
        && frame_wdata[0] == general_control_one[0] |=> fail_safe ##1 fail_safe)
        else $error("Unchanged toggle write did not enter fail safe");
    a_toggle_ok: assert property (
        !fail_safe && wr_frame && frame_addr == gcr_pkg::OFS_GCTRL1
        && frame_wdata[0] != general_control_one[0] && !wdg.expired |=> !fail_safe)
        else $error("Inverted toggle write entered fail safe");
    a_disable_locked: assert property (
        wr_frame && frame_addr == gcr_pkg::OFS_GCTRL2 && frame_wdata[9]
        && !unlock_prev && watchdog_active |=> watchdog_active)
        else $error("Watchdog disabled without unlock frame");
    a_disable_unlocked: assert property (
        unlock_prev && wr_frame && frame_addr == gcr_pkg::OFS_GCTRL2 && frame_wdata[9]
        |=> !watchdog_active)
        else $error("Unlocked disable write did not stop watchdog");
    a_reenable_now: assert property (
        wr_frame && frame_addr == gcr_pkg::OFS_GCTRL2 && !frame_wdata[9] |=> watchdog_active)
        else $error("Clearing disable bit did not re-enable watchdog");
    a_reserved_zero: assert property (
        general_control_one[6] == 1'b0 && general_control_one[4] == 1'b0)
        else $error("Reserved bit of control one is set");
    a_bank_route: assert property (
        frame_done && gcr_pkg::is_banked(frame_addr)
        |=> ext_valid && ext_bank_alt == $past(general_control_one[9]))
        else $error("Banked address routed with wrong bank");
    a_frame_only: assert property (
        !frame_done |=> $stable(general_control_two) && $stable(pwm2_switch_delays))
        else $error("Register changed outside a frame");
    a_read_latency: assert property (
        frame_done && !frame_wr |=> !frame_rvalid ##1 frame_rvalid)
        else $error("Read answer not two cycles after frame");
endmodule
`default_nettype wire

/* rtl/gcr_pkg.sv */
// Constants, offsets and field positions of the general control register bank.
package gcr_pkg;

    // Frame addresses of the registers held in this bank.
    localparam logic [4:0]  OFS_GCTRL1   = 5'h00;
    localparam logic [4:0]  OFS_GCTRL2   = 5'h01;
    localparam logic [4:0]  OFS_PWM2_DLY = 5'h0F;
    localparam logic [4:0]  OFS_PWM3_DLY = 5'h10;

    // Addresses whose physical target depends on the bank select bit.
    localparam logic [4:0]  OFS_BANKED_A = 5'h05;
    localparam logic [4:0]  OFS_BANKED_B = 5'h0A;
    localparam logic [4:0]  OFS_BANKED_C = 5'h0B;
    localparam logic [4:0]  OFS_BANKED_D = 5'h0C;
    localparam logic [4:0]  OFS_BANKED_E = 5'h0D;

    // Values after reset, and the write mask of control one.
    localparam logic [15:0] RST_GCTRL1   = 16'h0026;
    localparam logic [15:0] RST_GCTRL2   = 16'h4180;
    localparam logic [15:0] RST_DLY      = 16'h0A0A;
    localparam logic [15:0] GCTRL1_WMASK = 16'hFFAF;

    // Field positions of general control register one.
    localparam int B1_TOGGLE     = 0;
    localparam int B1_PERIOD     = 1;
    localparam int B1_OC_EN      = 2;
    localparam int B1_ADAPT_STEP = 3;
    localparam int B1_SPREAD     = 5;
    localparam int B1_UNLOCK     = 7;
    localparam int B1_OV_LEVEL   = 8;
    localparam int B1_BANK       = 9;
    localparam int B1_GAIN1_LO   = 10;
    localparam int B1_DIR1       = 12;
    localparam int B1_GAIN2_LO   = 13;
    localparam int B1_DIR2       = 15;

    // Field positions of general control register two.
    localparam int B2_WDG_DIS    = 9;
    localparam int B2_HOLD       = 10;
    localparam int B2_AGC_LO     = 11;
    localparam int B2_FILTER     = 13;
    localparam int B2_PASSIVE    = 14;
    localparam int B2_POST_DIS   = 15;

    localparam logic [1:0]  AGC_OFF      = 2'h0;
    localparam logic [1:0]  AGC_PREDIS   = 2'h1;
    localparam logic [6:0]  GAIN_BASE    = 7'h0A;

    // Timing at the 20 MHz system clock.
    localparam int CLK_HZ             = 20000000;
    localparam int CLK_NS             = 50;
    localparam int MS_NS              = 1000000;
    localparam int CYC_PER_MS         = MS_NS / CLK_NS;
    localparam int WDG_SHORT_MS       = 50;
    localparam int WDG_LONG_MS        = 200;
    localparam int SPREAD_KHZ_X10     = 156;
    localparam int SPREAD_CYC         = CLK_HZ / (SPREAD_KHZ_X10 * 100);

    function automatic logic is_banked(input logic [4:0] addr);
        return (addr == OFS_BANKED_A) || (addr == OFS_BANKED_B) || (addr == OFS_BANKED_C)
            || (addr == OFS_BANKED_D) || (addr == OFS_BANKED_E);
    endfunction

endpackage

/* rtl/gcr_watchdog.sv */
// Watchdog timer counting millisecond ticks between valid toggle writes.
`timescale 1ns/1ns
`default_nettype none
module gcr_watchdog #(
    parameter int CYC_PER_MS = gcr_pkg::CYC_PER_MS
) (
    input  wire logic   clk,
    input  wire logic   rst_sync_b,
    gcr_wdg_if.timer    wdg
);
    localparam int DW = $clog2(CYC_PER_MS + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(CYC_PER_MS - 1);
    localparam logic [7:0] LIM_SHORT = 8'(gcr_pkg::WDG_SHORT_MS);
    localparam logic [7:0] LIM_LONG  = 8'(gcr_pkg::WDG_LONG_MS);

    logic [DW-1:0] div_cnt;
    logic [DW-1:0] next_div_cnt;
    logic [7:0]    ms_cnt;
    logic [7:0]    next_ms_cnt;
    logic          expired;
    logic          next_expired;
    logic          ms_tick;
    logic [7:0]    limit;

    always_comb begin
        ms_tick      = (div_cnt == DIV_LAST);
        limit        = wdg.period_long ? LIM_LONG : LIM_SHORT;
        next_div_cnt = ms_tick ? '0 : div_cnt + DW'(1);
        next_ms_cnt  = ms_cnt;
        next_expired = 1'b0;
        // A kick or a stopped watchdog restarts the whole window.
        if (wdg.kick || !wdg.enable) begin
            next_div_cnt = '0;
            next_ms_cnt  = '0;
        end else if (ms_tick) begin
            if (ms_cnt == limit - 8'h01) begin
                next_expired = 1'b1;
                next_ms_cnt  = '0;
            end else begin
                next_ms_cnt = ms_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            div_cnt <= '0;
            ms_cnt  <= '0;
            expired <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            ms_cnt  <= next_ms_cnt;
            expired <= next_expired;
        end
    end

    assign wdg.expired = expired;
endmodule
`default_nettype wire

/* rtl/gcr_wdg_if.sv */
// Signals between the register bank and its watchdog timer.
`timescale 1ns/1ns
`default_nettype none
interface gcr_wdg_if;
    logic kick;
    logic enable;
    logic period_long;
    logic expired;
    modport ctrl  (output kick, output enable, output period_long, input expired);
    modport timer (input kick, input enable, input period_long, output expired);
endinterface
`default_nettype wire

/* test/gcr_host.sv */
// Host model that drives whole serial frames into the register bank.
`timescale 1ns/1ns
`default_nettype none
module gcr_host (
    input  wire logic        clk,
    input  wire logic        frame_rvalid,
    input  wire logic [15:0] frame_rdata,
    output logic             frame_done,
    output logic             frame_wr,
    output logic      [4:0]  frame_addr,
    output logic      [15:0] frame_wdata
);
    initial begin
        frame_done  = 1'b0;
        frame_wr    = 1'b0;
        frame_addr  = 5'h1F;
        frame_wdata = 16'hFFFF;
    end
    // Address and data are inverted between frames so a stale value never passes.
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge clk);
        frame_done  <= 1'b1;
        frame_wr    <= wr;
        frame_addr  <= a;
        frame_wdata <= d;
        @(posedge clk);
        frame_done  <= 1'b0;
        frame_addr  <= ~a;
        frame_wdata <= ~d;
        if (!wr) begin
            @(posedge clk);
        end
        #1;
        q = (frame_rvalid === 1'b1) ? frame_rdata : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench of the general control register bank.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        frame_done, frame_wr, frame_rvalid, ext_valid, ext_wr, ext_bank_alt;
    logic [4:0]  frame_addr, ext_addr, a;
    logic [15:0] frame_wdata, frame_rdata, ext_wdata, ext_rdata, q, d, m1, m2;
    logic [15:0] pwm2_switch_delays, pwm3_switch_delays;
    logic        fail_safe, watchdog_active, watchdog_period_select, overcurrent_enable;
    logic        precharge_adapt_step, spread_modulation, spread_tick, unl;
    logic        supply_overvoltage_level, bank_select, sense_direction_one;
    logic        sense_direction_two, postcharge_disable, bridge_passive;
    logic        adaptive_gate_filter, adapt_enable, precharge_enable;
    logic        predischarge_enable, gate_hold_current_select;
    logic [1:0]  sense_gain_one, sense_gain_two, adaptive_gate_mode;
    logic [6:0]  sense_gain_one_vpv, sense_gain_two_vpv;
    logic [8:0]  general_control_two_low;
    int          n_fail = 0;
    int          total_checks = 0;
    int          i;
    int          n_tick = 0;

    always #25 clk = ~clk;
    // Outside registers answer with a pattern that shows which bank was reached.
    assign ext_rdata = {ext_bank_alt, 6'h2A, 4'h0, ext_addr};

    gcr_general_control #(.CYC_PER_MS(20)) u_gcr_general_control (.*);
    gcr_host u_gcr_host (.*);

    always @(posedge clk) if (spread_tick === 1'b1) n_tick <= n_tick + 1;
    // The bench never writes outside the bank, so forwarded frames are reads with zero data.
    always @(negedge clk) if (ext_valid === 1'b1) `CHK({ext_wr, ext_wdata}, 17'h00000)

    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        m1 = 16'h0026;
        m2 = 16'h4180;
        unl = 1'b0;
    endtask
    task automatic wr(input logic [4:0] wa, input logic [15:0] v);
        u_gcr_host.xfer(1'b1, wa, v, q);
        if (wa == 5'h00) m1 = v & 16'hFFAF;
        if (wa == 5'h01) m2 = {v[15:10], v[9] & (unl | m2[9]), v[8:0]};
        unl = (wa == 5'h00) && v[7];
    endtask
    task automatic wr1(input logic [15:0] v);
        wr(5'h00, {v[15:1], ~m1[0]});
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] e);
        u_gcr_host.xfer(1'b0, ra, 16'h0000, q);
        unl = 1'b0;
        `CHK(q, e)
    endtask
    task automatic chk_fields();
        `CHK(sense_gain_one_vpv, 7'(10 << m1[11:10]))
        `CHK(sense_gain_two_vpv, 7'(10 << m1[14:13]))
        `CHK({sense_direction_two, sense_direction_one}, {m1[15], m1[12]})
        `CHK({bank_select, supply_overvoltage_level, spread_modulation, precharge_adapt_step,
              watchdog_period_select}, {m1[9:8], m1[5], m1[3], m1[1]})
        `CHK({postcharge_disable, bridge_passive, adaptive_gate_filter, gate_hold_current_select,
              watchdog_active}, {m2[15:13], m2[10], ~m2[9]})
        `CHK({adapt_enable, precharge_enable, predischarge_enable},
             {m2[12], m2[12], m2[12:11] != 2'h0})
        `CHK({overcurrent_enable, sense_gain_two, sense_gain_one, adaptive_gate_mode,
              general_control_two_low}, {m1[2], m1[14:13], m1[11:10], m2[12:11], m2[8:0]})
    endtask
    task automatic end_sim();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        n_fail++;
        end_sim();
    end
    initial begin
        void'($urandom(45));
        do_reset();
        rd(5'h00, 16'h0026);
        rd(5'h01, 16'h4180);
        rd(5'h0F, 16'h0A0A);
        rd(5'h10, 16'h0A0A);
        chk_fields();
        for (i = 0; i < 12; i++) begin
            wr1(16'($urandom));
            chk_fields();
            rd(5'h00, m1);
            a = 5'($urandom_range(2, 14));
            rd(a, {m1[9] && (a inside {5'h05, 5'h0A, 5'h0B, 5'h0C, 5'h0D}), 6'h2A, 4'h0, a});
            d = 16'($urandom);
            wr(5'h0F + 5'(i % 2), d);
            `CHK((i % 2) ? pwm3_switch_delays : pwm2_switch_delays, d)
        end
        for (i = 0; i < 4; i++) begin
            d = 16'($urandom);
            d[12:11] = 2'(i);
            d[9] = 1'b0;
            wr(5'h01, d);
            chk_fields();
            rd(5'h01, m2);
        end
        wr(5'h01, m2 | 16'h0200);
        chk_fields();
        wr1(m1 | 16'h0080);
        wr(5'h0F, d);
        wr(5'h01, m2 | 16'h0200);
        chk_fields();
        wr1(m1 | 16'h00A0);
        wr(5'h01, m2 | 16'h0200);
        chk_fields();
        n_tick <= 0;
        repeat (4100) @(posedge clk);
        `CHK(fail_safe, 1'b0)
        `CHK(n_tick inside {3, 4}, 1'b1)
        wr(5'h01, m2 & 16'hFDFF);
        chk_fields();
        wr1(m1 & 16'hFFFD);
        repeat (950) @(posedge clk);
        `CHK(fail_safe, 1'b0)
        repeat (110) @(posedge clk);
        `CHK(fail_safe, 1'b1)
        do_reset();
        `CHK(fail_safe, 1'b0)
        wr(5'h00, 16'h0026);
        `CHK(fail_safe, 1'b1)
        end_sim();
    end
endmodule
`default_nettype wire
